// ---- rtl/ivp_top.sv ----
`timescale 1ns/1ps
`include "ivp_defs.svh"

// Function
// R1: Reset starts at address zero by default
// R2: Twenty-six vectors, two words apart
// R3: Programmed boot fuse moves reset vector
// R4: Select bit adds boot start to vectors
// R5: Fuse and select bit act independently
// R6: Boot start comes from boot-size fuses
// R7: Software arms enable, then writes select
// R8: Enable clears after four cycles or write
// R9: Interrupts blocked during the change sequence
// R10: Global interrupt enable left untouched
// R11: App lock blocks interrupts outside boot
// R12: Boot lock blocks interrupts inside boot
// R13: Smallest variant has no select bit
// R14: Unarmed select write is ignored
module ivp_top #(
  parameter logic        HAS_VSEL    = 1'b1,
  parameter logic [12:0] BOOT_START0 = 13'h1c00,
  parameter logic [12:0] BOOT_START1 = 13'h1e00,
  parameter logic [12:0] BOOT_START2 = 13'h1f00,
  parameter logic [12:0] BOOT_START3 = 13'h1f80
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               boot_reset_fuse,
  input  wire logic [1:0]         boot_size_fuses,
  input  wire logic               app_side_lock_bit,
  input  wire logic               boot_side_lock_bit,
  input  wire logic               exec_in_boot,
  input  wire logic               instr_done,
  input  wire logic               global_ie,
  input  wire logic [4:0]         vec_index,
  output ivp_pkg::ivp_addr_t      reset_vector,
  output ivp_pkg::ivp_addr_t      vector_addr,
  output logic                    vec_bad,
  output logic                    irq_enable,
  output logic                    pullup_disable
);

  ivp_ctrl_if ctl ();

  ivp_pkg::ivp_seq_t seq_state;
  logic [2:0]        chg_cnt;
  logic              vector_select_bit;
  logic              vector_change_enable;
  ivp_pkg::ivp_addr_t boot_start;

  logic hit_ctrl;
  logic hit_stat;
  logic setup;
  logic wr_xfer;
  logic ctrl_wr;
  logic wr_ce;
  logic wr_sel;
  logic [7:0] ctrl_rd;
  logic [7:0] stat_rd;

  // Reset image of the control register, taken bit by bit
  localparam logic [7:0] CTRL_RST = `IVP_CTRL_RST;

  // ==========================================================
  // APB decode
  assign hit_ctrl = (paddr[7:2] == `IVP_CTRL_IDX) && (paddr[1:0] == 2'b00);
  assign hit_stat = (paddr[7:2] == `IVP_STAT_IDX) && (paddr[1:0] == 2'b00);
  assign setup    = psel && !penable;
  assign wr_xfer  = psel && penable && pready && pwrite;
  assign ctrl_wr  = wr_xfer && hit_ctrl;
  assign wr_ce    = pwdata[`IVP_VCE_BIT];
  assign wr_sel   = pwdata[`IVP_VSEL_BIT];

  assign vector_change_enable = (seq_state == ivp_pkg::SEQ_ARMED);

  assign ctrl_rd = {3'h0, pullup_disable, 2'h0, vector_select_bit,
                    vector_change_enable};
  assign stat_rd = {irq_enable, chg_cnt, boot_size_fuses,
                    boot_reset_fuse, ctl.seq_block};

  // Answer in the first access cycle: one setup, one access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // Data sampled at setup; address and direction stay put
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      if (pwrite) begin
        prdata <= 32'h0000_0000;
      end else if (hit_ctrl) begin
        prdata <= {24'h00_0000, ctrl_rd};
      end else if (hit_stat) begin
        prdata <= {24'h00_0000, stat_rd};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Error stands only in the access cycle, beside pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup && !(hit_ctrl || hit_stat);
    end
  end

  // ==========================================================
  // Plain control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_disable <= CTRL_RST[`IVP_PUD_BIT];
    end else if (ctrl_wr) begin
      pullup_disable <= pwdata[`IVP_PUD_BIT];
    end
  end

  // Fuses are static, a register keeps the adder off their pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_start <= 13'h0000;
    end else begin
      unique case (boot_size_fuses) // R6
        2'h0: boot_start <= BOOT_START0;
        2'h1: boot_start <= BOOT_START1;
        2'h2: boot_start <= BOOT_START2;
        2'h3: boot_start <= BOOT_START3;
      endcase
    end
  end

  // ==========================================================
  // Timed change sequence
  // A second arm while armed is ignored so the window never stretches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_state <= ivp_pkg::SEQ_IDLE;
    end else begin
      unique case (seq_state)
        ivp_pkg::SEQ_IDLE, ivp_pkg::SEQ_HOLD: begin
          if (ctrl_wr && wr_ce) begin
            seq_state <= ivp_pkg::SEQ_ARMED; // R7 R9
          end else if (seq_state == ivp_pkg::SEQ_HOLD && instr_done) begin
            seq_state <= ivp_pkg::SEQ_IDLE; // R9
          end
        end
        ivp_pkg::SEQ_ARMED: begin
          if (ctrl_wr && !wr_ce) begin
            seq_state <= ivp_pkg::SEQ_HOLD; // R8
          end else if (chg_cnt == 3'h1) begin
            seq_state <= ivp_pkg::SEQ_IDLE; // R8 R9
          end
        end
      endcase
    end
  end

  // Window counter runs only while armed and rests at zero otherwise
  // Its value is visible in status, so it must not drift when idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_cnt <= 3'h0;
    end else if (seq_state != ivp_pkg::SEQ_ARMED) begin
      if (ctrl_wr && wr_ce) begin
        chg_cnt <= `IVP_CHG_CYCLES; // R8
      end
    end else if (ctrl_wr && !wr_ce) begin
      chg_cnt <= 3'h0; // R8
    end else begin
      chg_cnt <= chg_cnt - 3'h1; // R8
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_select_bit <= 1'b0;
    end else if (HAS_VSEL && ctrl_wr && !wr_ce
                 && vector_change_enable) begin
      vector_select_bit <= wr_sel; // R7 R14 R13
    end
  end

  assign ctl.vector_select_bit = vector_select_bit;
  assign ctl.seq_block         = (seq_state != ivp_pkg::SEQ_IDLE); // R9
  assign ctl.boot_start        = boot_start;

  // ==========================================================
  // Submodules
  ivp_vec_gen u_vec (
    .pclk            (pclk),
    .presetn         (presetn),
    .ctl             (ctl.vec),
    .boot_reset_fuse (boot_reset_fuse),
    .vec_index       (vec_index),
    .reset_vector    (reset_vector),
    .vector_addr     (vector_addr),
    .vec_bad         (vec_bad)
  );

  ivp_irq_gate u_gate (
    .pclk               (pclk),
    .presetn            (presetn),
    .ctl                (ctl.gate),
    .app_side_lock_bit  (app_side_lock_bit),
    .boot_side_lock_bit (boot_side_lock_bit),
    .exec_in_boot       (exec_in_boot),
    .global_ie          (global_ie),
    .irq_enable         (irq_enable)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_CE_TIMEOUT: assert property ( // R8
    $rose(vector_change_enable) |-> ##[1:4] !vector_change_enable)
    else $error("change enable held beyond four cycles");

  AST_CE_FULL: assert property ( // R8
    ($rose(vector_change_enable) && !ctrl_wr)
      ##1 !ctrl_wr ##1 !ctrl_wr ##1 !ctrl_wr |->
      vector_change_enable ##1 !vector_change_enable)
    else $error("change enable not cleared at four cycles");

  AST_SEL_WRITE: assert property ( // R7
    (ctrl_wr && !wr_ce && vector_change_enable && HAS_VSEL) |=>
      (vector_select_bit == $past(wr_sel)) && !vector_change_enable)
    else $error("armed select write not applied");

  AST_UNARMED: assert property ( // R14
    (ctrl_wr && !vector_change_enable) |=> $stable(vector_select_bit))
    else $error("select bit changed without arming");

  AST_BLOCK: assert property ( // R9
    $rose(vector_change_enable) |=> !irq_enable [*4])
    else $error("interrupts not blocked while armed");

  AST_HOLD: assert property ( // R9
    (seq_state == ivp_pkg::SEQ_HOLD && !instr_done) |=> !irq_enable)
    else $error("interrupts released before next instruction");

  AST_SMALL: assert property ( // R13
    !HAS_VSEL |-> !vector_select_bit)
    else $error("select bit set on variant without it");

  AST_APB_READY: assert property (
    setup |=> pready ##1 !pready)
    else $error("slave answer not in first access cycle");

  // ==========================================================
  // Bus side checks
  AST_APB_IDLE: assert property (
    !setup |=> !pready)
    else $error("slave answer without a setup cycle");

  AST_APB_ERR: assert property (
    pslverr |-> pready)
    else $error("slave error outside the access cycle");

  AST_APB_WZERO: assert property (
    (setup && pwrite) |=> prdata == 32'h0000_0000)
    else $error("read data not zero on a write");

  AST_WR_IGNORED: assert property (
    (wr_xfer && !hit_ctrl) |=>
      $stable(pullup_disable) && $stable(vector_select_bit))
    else $error("control bits changed by a write elsewhere");

  AST_PUD_WRITE: assert property (
    ctrl_wr |=> pullup_disable == $past(pwdata[`IVP_PUD_BIT]))
    else $error("pull-up disable bit not written");

  // ==========================================================
  // Change window checks
  AST_CE_SOURCE: assert property ( // R8
    $rose(vector_change_enable) |-> $past(ctrl_wr && wr_ce))
    else $error("change enable set without an arm write");

  AST_ARM_LOAD: assert property ( // R8
    (ctrl_wr && wr_ce && !vector_change_enable) |=>
      vector_change_enable && chg_cnt == `IVP_CHG_CYCLES)
    else $error("arm write did not load the change window");

  AST_NO_REARM: assert property ( // R8
    (ctrl_wr && wr_ce && vector_change_enable) |=>
      chg_cnt == $past(chg_cnt) - 3'h1)
    else $error("arm write while armed restarted the window");

  AST_CNT_IDLE: assert property ( // R8
    !vector_change_enable |-> chg_cnt == 3'h0)
    else $error("change counter running while not armed");

  AST_ARM_KEEP: assert property ( // R14
    (ctrl_wr && wr_ce) |=> $stable(vector_select_bit))
    else $error("select bit changed by an arm write");

  AST_BLOCK_SRC: assert property ( // R9
    ctl.seq_block |=> !irq_enable)
    else $error("interrupts open while the sequence runs");

  AST_HOLD_END: assert property ( // R9
    (seq_state == ivp_pkg::SEQ_HOLD && instr_done && !(ctrl_wr && wr_ce))
      |=> seq_state == ivp_pkg::SEQ_IDLE)
    else $error("block not lifted after the next instruction");

  AST_IE_ONLY: assert property ( // R10
    !global_ie |=> !irq_enable)
    else $error("interrupts enabled against the global enable");

  // Reset edge excluded: the flop is still cleared there
  AST_IRQ_FREE: assert property ( // R10
    (presetn && !ctl.seq_block && global_ie && app_side_lock_bit
      && boot_side_lock_bit) |=> irq_enable)
    else $error("interrupts blocked with no cause");

  COV_MOVE: cover property (
    ctrl_wr && !wr_ce && vector_change_enable && wr_sel);
  COV_EXPIRE: cover property (
    vector_change_enable ##1 !vector_change_enable && !ctrl_wr);
  COV_IGNORED: cover property (ctrl_wr && !wr_ce && !vector_change_enable);
  COV_BADADDR: cover property (pslverr);
  COV_HOLD_END: cover property (seq_state == ivp_pkg::SEQ_HOLD && instr_done);

endmodule

// ---- include/ivp_defs.svh ----
`ifndef IVP_DEFS_SVH
`define IVP_DEFS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define IVP_CTRL_IDX    6'h35
`define IVP_STAT_IDX    6'h36

// ==========================================================
// Control register fields and reset value
`define IVP_VCE_BIT     0
`define IVP_VSEL_BIT    1
`define IVP_PUD_BIT     4
`define IVP_CTRL_RST    8'h00

// ==========================================================
// Status register fields
`define IVP_ST_BLOCK    0
`define IVP_ST_FUSE     1
`define IVP_ST_SIZE_LO  2
`define IVP_ST_CNT_LO   4
`define IVP_ST_IRQ_EN   7

// ==========================================================
// Timing and vector table
`define IVP_CHG_CYCLES  3'h4
`define IVP_VEC_COUNT   5'h1a
`define IVP_RESET_ADDR  13'h0000

`endif

// ---- include/ivp_pkg.sv ----
package ivp_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_ARMED,
    SEQ_HOLD
  } ivp_seq_t;

  typedef logic [12:0] ivp_addr_t;

endpackage

// ---- include/ivp_ctrl_if.sv ----
`timescale 1ns/1ps

interface ivp_ctrl_if;
  logic              vector_select_bit;
  logic              seq_block;
  ivp_pkg::ivp_addr_t boot_start;

  modport ctrl (
    output vector_select_bit,
    output seq_block,
    output boot_start
  );
  modport vec (
    input vector_select_bit,
    input boot_start
  );
  modport gate (
    input vector_select_bit,
    input seq_block
  );
endinterface

// ---- rtl/ivp_vec_gen.sv ----
`timescale 1ns/1ps
`include "ivp_defs.svh"

module ivp_vec_gen (
  input  wire logic               pclk,
  input  wire logic               presetn,
  ivp_ctrl_if.vec                 ctl,
  input  wire logic               boot_reset_fuse,
  input  wire logic [4:0]         vec_index,
  output ivp_pkg::ivp_addr_t      reset_vector,
  output ivp_pkg::ivp_addr_t      vector_addr,
  output logic                    vec_bad
);

  ivp_pkg::ivp_addr_t next_reset;
  ivp_pkg::ivp_addr_t table_base;
  ivp_pkg::ivp_addr_t slot_offset;

  // ==========================================================
  // Address forming
  // Fuse programmed reads as zero
  assign next_reset  = boot_reset_fuse ? `IVP_RESET_ADDR
                                       : ctl.boot_start; // R1 R3 R5
  assign table_base  = ctl.vector_select_bit ? ctl.boot_start
                                             : `IVP_RESET_ADDR; // R4 R6
  // Two program words per slot
  assign slot_offset = {7'h00, vec_index, 1'b0}; // R2

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_vector <= 13'h0000;
    end else begin
      reset_vector <= next_reset; // R1 R3
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_addr <= 13'h0000;
      vec_bad     <= 1'b0;
    end else begin
      // Slot zero is the reset entry, it follows the fuse only
      if (vec_index == 5'h00) begin
        vector_addr <= next_reset; // R5
      end else begin
        vector_addr <= table_base + slot_offset; // R2 R4
      end
      vec_bad <= (vec_index >= `IVP_VEC_COUNT); // R2
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Attempts from the reset edge itself would see reset values
  AST_RESET_ADDR: assert property ( // R3
    presetn |=> reset_vector ==
      ($past(boot_reset_fuse) ? 13'h0000 : $past(ctl.boot_start)))
    else $error("reset vector does not follow boot reset fuse");

  AST_VEC_ADDR: assert property ( // R4
    (presetn && vec_index != 5'h00) |=> vector_addr ==
      ($past(ctl.vector_select_bit) ? $past(ctl.boot_start) : 13'h0000)
      + {7'h00, $past(vec_index), 1'b0})
    else $error("interrupt vector address wrong");

  AST_VEC_LAST: assert property ( // R2
    (presetn && vec_index == 5'h19 && !ctl.vector_select_bit) |=>
      vector_addr == 13'h0032)
    else $error("last vector not at 0x0032");

endmodule

// ---- rtl/ivp_irq_gate.sv ----
`timescale 1ns/1ps

module ivp_irq_gate (
  input  wire logic pclk,
  input  wire logic presetn,
  ivp_ctrl_if.gate  ctl,
  input  wire logic app_side_lock_bit,
  input  wire logic boot_side_lock_bit,
  input  wire logic exec_in_boot,
  input  wire logic global_ie,
  output logic      irq_enable
);

  logic app_lock_block;
  logic boot_lock_block;

  // ==========================================================
  // Lock bits are programmed when zero
  assign app_lock_block  = ctl.vector_select_bit && !app_side_lock_bit
                           && !exec_in_boot; // R11
  assign boot_lock_block = !ctl.vector_select_bit && !boot_side_lock_bit
                           && exec_in_boot; // R12

  // Global enable is only read, never written back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable <= 1'b0;
    end else begin
      irq_enable <= global_ie && !ctl.seq_block
                    && !app_lock_block && !boot_lock_block; // R9 R10
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_LOCK_APP: assert property ( // R11
    (ctl.vector_select_bit && !app_side_lock_bit && !exec_in_boot)
      |=> !irq_enable)
    else $error("interrupt taken from application with app lock");

  AST_LOCK_BOOT: assert property ( // R12
    (!ctl.vector_select_bit && !boot_side_lock_bit && exec_in_boot)
      |=> !irq_enable)
    else $error("interrupt taken from boot section with boot lock");

endmodule

// ---- tb/ivp_core_model.sv ----
`timescale 1ns/1ps
`include "ivp_defs.svh"

// ==========================================================
// Core side: register writes over APB and retired instructions
module ivp_core_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic             instr_done
);
  localparam logic [7:0] CA = {`IVP_CTRL_IDX, 2'b00};
  bit          run = 1'b1;
  int          cnt = 0;
  logic [31:0] q;
  logic        e;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    instr_done = 1'b0;
  end

  // One retired instruction every eighth cycle while running
  always @(posedge pclk) begin
    cnt <= (cnt == 7) ? 0 : cnt + 1;
    instr_done <= run && (cnt == 7);
  end

  // Called just after a rising edge; rel=0 leaves the access up and the
  // follow-on call lowers penable, so no line is set twice in one step
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic rel,
      output logic [31:0] rq, output logic re);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rq = prdata;
    re = pslverr;
    if (rel) begin
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle lines never show the last value
      paddr <= ~a;
      pwdata <= ~d;
      pwrite <= ~w;
      @(posedge pclk);
    end
  endtask

  // Back to back, since one transfer takes two of the four cycles
  task automatic move(input logic v);
    xfer(1'b1, CA, 32'h1, 1'b0, q, e);
    xfer(1'b1, CA, {30'h0, v, 1'b0}, 1'b1, q, e);
  endtask
endmodule

// ---- tb/test_interrupt_vector_placement.sv ----
`timescale 1ns/1ps
`include "ivp_defs.svh"

module test_interrupt_vector_placement;
  localparam logic [12:0] BS [4] = '{13'h1c00, 13'h1e00, 13'h1f00, 13'h1f80};
  localparam logic [7:0]  CA = {`IVP_CTRL_IDX, 2'b00};
  localparam logic [7:0]  SA = {`IVP_STAT_IDX, 2'b00};
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel, penable, pwrite, pready, pslverr;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, q;
  logic               e, vs, instr_done, vec_bad, irq_enable;
  logic               boot_reset_fuse, app_side_lock_bit, boot_side_lock_bit;
  logic               exec_in_boot, global_ie, pullup_disable;
  logic [1:0]         boot_size_fuses;
  logic [4:0]         vec_index;
  ivp_pkg::ivp_addr_t reset_vector, vector_addr, small_addr;
  int                 n_mismatch = 0;
  int                 checked = 0;
  int                 cycles = 0;

  always #5 pclk = ~pclk;

  ivp_core_model i_core (.pclk(pclk), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .instr_done(instr_done));

  ivp_top #(.BOOT_START0(BS[0]), .BOOT_START1(BS[1]),
    .BOOT_START2(BS[2]), .BOOT_START3(BS[3])) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .boot_reset_fuse(boot_reset_fuse),
    .boot_size_fuses(boot_size_fuses), .app_side_lock_bit(app_side_lock_bit),
    .boot_side_lock_bit(boot_side_lock_bit), .exec_in_boot(exec_in_boot),
    .instr_done(instr_done), .global_ie(global_ie), .vec_index(vec_index),
    .reset_vector(reset_vector), .vector_addr(vector_addr),
    .vec_bad(vec_bad), .irq_enable(irq_enable),
    .pullup_disable(pullup_disable));

  // Smallest variant sees the same traffic but must never relocate
  ivp_top #(.HAS_VSEL(1'b0), .BOOT_START0(BS[0]), .BOOT_START1(BS[1]),
    .BOOT_START2(BS[2]), .BOOT_START3(BS[3])) i_dut_small (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
    .pready(), .pslverr(), .boot_reset_fuse(boot_reset_fuse),
    .boot_size_fuses(boot_size_fuses), .app_side_lock_bit(app_side_lock_bit),
    .boot_side_lock_bit(boot_side_lock_bit), .exec_in_boot(exec_in_boot),
    .instr_done(instr_done), .global_ie(global_ie), .vec_index(vec_index),
    .reset_vector(), .vector_addr(small_addr), .vec_bad(), .irq_enable(),
    .pullup_disable());

  // ==========================================================
  // Expectations and checks
  function automatic logic [12:0] f_vec(input logic [4:0] ix,
      input logic s, input logic f, input logic [1:0] z);
    if (ix == 5'h00) return f ? `IVP_RESET_ADDR : BS[z];
    return (s ? BS[z] : 13'h0000) + {7'h00, ix, 1'b0};
  endfunction

  function automatic logic f_irq(input logic s);
    return global_ie && !(s && !app_side_lock_bit && !exec_in_boot)
      && !(!s && !boot_side_lock_bit && exec_in_boot);
  endfunction

  task automatic chk(input string nm, input logic [31:0] x,
      input logic [31:0] s);
    checked++;
    if (s !== x) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_core.xfer(w, a, d, 1'b1, q, e);
  endtask

  task automatic wait_irq;
    repeat (24) begin
      @(posedge pclk);
      #1;
      if (irq_enable === 1'b1) break;
    end
    chk("irq restored", 32'h1, {31'h0, irq_enable});
    @(posedge pclk);
  endtask

  task automatic sweep(input int n);
    logic [4:0] ix;
    for (int i = 0; i < n; i++) begin
      ix = (i == 0) ? 5'h00 : (i == 1) ? 5'h19 : (i == 2) ? 5'h1a
        : 5'($urandom);
      @(posedge pclk);
      vec_index <= ix;
      boot_reset_fuse <= 1'($urandom);
      boot_size_fuses <= 2'($urandom);
      app_side_lock_bit <= 1'($urandom);
      boot_side_lock_bit <= 1'($urandom);
      exec_in_boot <= 1'($urandom);
      global_ie <= 1'($urandom);
      repeat (2) @(posedge pclk);
      #1;
      chk("reset vector", 32'(f_vec(5'h00, vs, boot_reset_fuse,
        boot_size_fuses)), 32'(reset_vector));
      chk("vec bad", 32'(ix >= `IVP_VEC_COUNT), 32'(vec_bad));
      if (ix < `IVP_VEC_COUNT) begin
        chk("vector", 32'(f_vec(ix, vs, boot_reset_fuse,
          boot_size_fuses)), 32'(vector_addr));
        chk("small vector", 32'(f_vec(ix, 1'b0, boot_reset_fuse,
          boot_size_fuses)), 32'(small_addr));
      end
      chk("irq gate", 32'(f_irq(vs)), 32'(irq_enable));
    end
    @(posedge pclk);
    app_side_lock_bit <= 1'b1;
    boot_side_lock_bit <= 1'b1;
    global_ie <= 1'b1;
  endtask

  task automatic results;
    if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      results();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(22));
    vs = 1'b0;
    boot_reset_fuse = 1'b1;
    boot_size_fuses = 2'h3;
    app_side_lock_bit = 1'b1;
    boot_side_lock_bit = 1'b1;
    exec_in_boot = 1'b0;
    global_ie = 1'b1;
    vec_index = 5'h01;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rw(1'b0, CA, 32'h0);
    chk("ctrl reset", 32'h0, q);
    rw(1'b0, SA, 32'h0);
    chk("status fuses", 32'h7, {29'h0, q[3:1]});
    rw(1'b0, 8'hd0, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    rw(1'b1, CA | 8'h01, 32'h1);
    chk("misaligned err", 32'h1, {31'h0, e});
    rw(1'b1, CA, 32'h12);
    rw(1'b0, CA, 32'h0);
    chk("ctrl unarmed", 32'h10, q);
    chk("pullup", 32'h1, {31'h0, pullup_disable});
    sweep(30);
    // Arm and let the window run out
    rw(1'b1, CA, 32'h1);
    for (int i = 0; i < 3; i++) begin
      @(posedge pclk);
      #1;
      chk("irq armed", 32'h0, {31'h0, irq_enable});
    end
    repeat (4) @(posedge pclk);
    rw(1'b0, CA, 32'h0);
    chk("enable expiry", 32'h00, q);
    chk("irq after expiry", 32'h1, {31'h0, irq_enable});
    rw(1'b1, CA, 32'h02);
    rw(1'b0, CA, 32'h0);
    chk("late select", 32'h0, q);
    // Block must outlast four cycles until an instruction retires
    i_core.run = 1'b0;
    i_core.move(1'b1);
    vs = 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      #1;
      chk("irq held", 32'h0, {31'h0, irq_enable});
    end
    i_core.run = 1'b1;
    wait_irq();
    rw(1'b0, CA, 32'h0);
    chk("ctrl moved", 32'h02, q);
    sweep(30);
    i_core.move(1'b0);
    vs = 1'b0;
    wait_irq();
    sweep(10);
    results();
  end
endmodule
